// >>> bench/ivp_host.sv
// Host model issuing command requests on the transport side
`default_nettype none

module ivp_host (
	// Clock
	input wire logic        clock,
	// Command port
	output var logic        cmd_req,
	output var logic        cmd_wr,
	output var logic [7:0]  cmd_code,
	output var logic [15:0] cmd_wdata,
	input wire logic        rsp_hit,
	input wire logic [15:0] rsp_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		cmd_req = 1'b0;
		cmd_wr = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
	end

	// Callers keep action writes out of shutdown windows
	task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] wd,
		output logic [15:0] rd, output logic hit);
		@(posedge clock);
		#1;
		cmd_req = 1'b1;
		cmd_wr = wr;
		cmd_code = code;
		cmd_wdata = wd;
		@(posedge clock);
		#1;
		rd = rsp_rdata;
		hit = rsp_hit;
		// Idle lines show junk so stale values cannot pass
		cmd_req = 1'b0;
		cmd_wr = ~wr;
		cmd_code = ~code;
		cmd_wdata = ~wd;
	endtask
endmodule
`default_nettype wire

// >>> bench/ivp_regs_props.sv
// Concurrent checks on the protection register ports
`default_nettype none
`include "ivp_defines.vh"

module ivp_regs_props #(
	parameter HICCUP_BASE_CYC = 8
) (
	// Clock and reset
	input wire logic        clock,
	input wire logic        rst_b,
	// Command port
	input wire logic        cmd_req,
	input wire logic        cmd_wr,
	input wire logic [7:0]  cmd_code,
	input wire logic [15:0] cmd_wdata,
	input wire logic        rsp_valid,
	input wire logic        rsp_hit,
	input wire logic [15:0] rsp_rdata,
	// Control and status
	input wire logic        nvm_restore,
	input wire logic        unit_on,
	input wire logic        status_clear,
	input wire logic        input_overvoltage_fault_flag,
	input wire logic        input_overvoltage_warning_flag,
	input wire logic        input_undervoltage_warning_flag,
	input wire logic        invalid_data_flag,
	input wire logic        other_fault_summary_bit,
	input wire logic        status_word_input_bit,
	input wire logic        cml_summary_bit,
	input wire logic        alert_b,
	input wire logic        conv_enable,
	input wire logic        shutdown_active
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	wire any_in = input_overvoltage_fault_flag | input_overvoltage_warning_flag |
		input_undervoltage_warning_flag;
	wire bad_act = cmd_wdata[7:3] != `IVP_ACT_IGNORE && cmd_wdata[7:3] != `IVP_ACT_LATCH &&
		cmd_wdata[7:3] != `IVP_ACT_HICCUP;

	sequence s_bad_act;
		cmd_req && cmd_wr && cmd_code == `IVP_CMD_OV_ACTION && bad_act && !nvm_restore;
	endsequence
	sequence s_trip;
		$rose(shutdown_active) && unit_on;
	endsequence

	property p_rsp; cmd_req |=> rsp_valid; endproperty
	a_rsp: assert property (p_rsp) else $error("no answer to request");
	property p_idle; !cmd_req |=> !rsp_valid; endproperty
	a_idle: assert property (p_idle) else $error("answer without request");
	property p_hit;
		cmd_req && cmd_code >= `IVP_CMD_OVF_LIMIT && cmd_code <= `IVP_CMD_UVW_LIMIT |=> rsp_hit;
	endproperty
	a_hit: assert property (p_hit) else $error("known code missed");
	property p_act_rd;
		cmd_req && !cmd_wr && cmd_code == `IVP_CMD_OV_ACTION |=>
			rsp_rdata[15:8] == 8'h00 && rsp_rdata[2:0] == 3'h0;
	endproperty
	a_act_rd: assert property (p_act_rd) else $error("action byte spare bits set");
	property p_alert; any_in || invalid_data_flag |-> !alert_b; endproperty
	a_alert: assert property (p_alert) else $error("flag without alert");
	property p_summary;
		other_fault_summary_bit == any_in && status_word_input_bit == any_in;
	endproperty
	a_summary: assert property (p_summary) else $error("summary bits wrong");
	property p_cml; cml_summary_bit == invalid_data_flag; endproperty
	a_cml: assert property (p_cml) else $error("cml bit wrong");
	property p_inv; s_bad_act |=> invalid_data_flag && !alert_b; endproperty
	a_inv: assert property (p_inv) else $error("bad action not flagged");
	property p_sticky;
		$fell(input_overvoltage_warning_flag) |-> $past(status_clear);
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped alone");
	property p_shut; shutdown_active |-> !conv_enable; endproperty
	a_shut: assert property (p_shut) else $error("converting in shutdown");
	// A drop of unit_on legally ends the off time early
	property p_hold; s_trip |-> (!conv_enable [*8]) or (##[0:7] !unit_on); endproperty
	a_hold: assert property (p_hold) else $error("shutdown too short");
endmodule

bind ivp_regs ivp_regs_props #(.HICCUP_BASE_CYC(HICCUP_BASE_CYC)) ivp_regs_props_i (
	.clock(clock), .rst_b(rst_b), .cmd_req(cmd_req), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
	.cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_hit(rsp_hit), .rsp_rdata(rsp_rdata),
	.nvm_restore(nvm_restore), .unit_on(unit_on), .status_clear(status_clear),
	.input_overvoltage_fault_flag(input_overvoltage_fault_flag),
	.input_overvoltage_warning_flag(input_overvoltage_warning_flag),
	.input_undervoltage_warning_flag(input_undervoltage_warning_flag),
	.invalid_data_flag(invalid_data_flag), .other_fault_summary_bit(other_fault_summary_bit),
	.status_word_input_bit(status_word_input_bit), .cml_summary_bit(cml_summary_bit),
	.alert_b(alert_b), .conv_enable(conv_enable), .shutdown_active(shutdown_active));
`default_nettype wire

// >>> bench/ivp_regs_tb.sv
// Self-checking bench for the protection registers
`default_nettype none
`include "ivp_defines.vh"

module ivp_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic clock, rst_b, nvm_restore, unit_on, status_clear;
	logic [15:0] nvm_ovf_limit, nvm_ovw_limit, nvm_uvw_limit, vin_sense, vin_on_level;
	logic [4:0] nvm_ov_action;
	logic [1:0] protection_configuration;
	wire cmd_req, cmd_wr, rsp_valid, rsp_hit, ovf, ovw, uvw, inv, summ, inb, alert_b, conv, shut;
	wire cml;
	wire [7:0] cmd_code;
	wire [15:0] cmd_wdata, rsp_rdata;
	int n_fail = 0;
	int tests_run = 0;
	int n;
	logic [4:0] acts [3] = '{`IVP_ACT_IGNORE, `IVP_ACT_LATCH, `IVP_ACT_HICCUP};

	ivp_host ivp_host_i (.clock(clock), .cmd_req(cmd_req), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
		.cmd_wdata(cmd_wdata), .rsp_hit(rsp_hit), .rsp_rdata(rsp_rdata));
	ivp_regs #(.HICCUP_BASE_CYC(8)) ivp_regs_i (.clock(clock), .rst_b(rst_b),
		.cmd_req(cmd_req), .cmd_wr(cmd_wr), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
		.rsp_valid(rsp_valid), .rsp_hit(rsp_hit), .rsp_rdata(rsp_rdata),
		.nvm_restore(nvm_restore), .nvm_ovf_limit(nvm_ovf_limit),
		.nvm_ovw_limit(nvm_ovw_limit), .nvm_uvw_limit(nvm_uvw_limit),
		.nvm_ov_action(nvm_ov_action), .vin_sense(vin_sense), .vin_on_level(vin_on_level),
		.protection_configuration(protection_configuration), .unit_on(unit_on),
		.status_clear(status_clear), .input_overvoltage_fault_flag(ovf),
		.input_overvoltage_warning_flag(ovw), .input_undervoltage_warning_flag(uvw),
		.invalid_data_flag(inv), .other_fault_summary_bit(summ), .status_word_input_bit(inb),
		.cml_summary_bit(cml), .alert_b(alert_b), .conv_enable(conv), .shutdown_active(shut));

	task summarize;
		if (n_fail == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task step(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask
	task chk_word(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
		end
	endtask
	task chk_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
		end
	endtask
	task rd(input logic [7:0] code, input logic hit, input logic [15:0] exp);
		logic [15:0] d;
		logic h;
		ivp_host_i.cmd(1'b0, code, 16'h0000, d, h);
		chk_bit(rsp_valid, 1'b1);
		chk_bit(h, hit);
		chk_word(d, exp);
	endtask
	task wr(input logic [7:0] code, input logic [15:0] data);
		logic [15:0] d;
		logic h;
		ivp_host_i.cmd(1'b1, code, data, d, h);
	endtask
	task clr;
		status_clear = 1'b1;
		step(1);
		status_clear = 1'b0;
		step(1);
	endtask

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	initial begin
		#50000;
		n_fail++;
		summarize;
	end

	initial begin
		rst_b = 1'b0;
		nvm_restore = 1'b0;
		nvm_ovf_limit = 16'h0C66;
		nvm_ovw_limit = 16'h1280;
		nvm_uvw_limit = 16'h0420;
		nvm_ov_action = 5'h17;
		vin_sense = 16'h0000;
		vin_on_level = 16'h0600;
		protection_configuration = 2'h1;
		unit_on = 1'b1;
		status_clear = 1'b0;
		step(6);
		rst_b = 1'b1;
		step(3);
		rd(`IVP_CMD_OVF_LIMIT, 1'b1, 16'h000C);
		rd(`IVP_CMD_OV_ACTION, 1'b1, 16'h00B8);
		rd(`IVP_CMD_OVW_LIMIT, 1'b1, 16'h0013);
		rd(`IVP_CMD_UVW_LIMIT, 1'b1, 16'hF011);
		rd(8'h59, 1'b0, 16'h0000);
		wr(`IVP_CMD_OVW_LIMIT, 16'hF80B);
		rd(`IVP_CMD_OVW_LIMIT, 1'b1, 16'hF80B);
		// Out-of-range limits and an unlisted action are refused
		wr(`IVP_CMD_OVW_LIMIT, 16'h0014);
		chk_bit(inv, 1'b1);
		chk_bit(cml, 1'b1);
		chk_bit(alert_b, 1'b0);
		rd(`IVP_CMD_OVW_LIMIT, 1'b1, 16'hF80B);
		clr;
		wr(`IVP_CMD_UVW_LIMIT, 16'hF00F);
		chk_bit(inv, 1'b1);
		rd(`IVP_CMD_UVW_LIMIT, 1'b1, 16'hF011);
		clr;
		wr(`IVP_CMD_OV_ACTION, 16'h0008);
		chk_bit(inv, 1'b1);
		rd(`IVP_CMD_OV_ACTION, 1'b1, 16'h00B8);
		clr;
		for (int i = 0; i < 3; i++) begin
			wr(`IVP_CMD_OV_ACTION, {8'h00, acts[i], 3'h7});
			rd(`IVP_CMD_OV_ACTION, 1'b1, {8'h00, acts[i], 3'h0});
			chk_bit(inv, 1'b0);
			chk_bit(cml, 1'b0);
		end
		// Restore in the same cycle as a write wins
		fork
			wr(`IVP_CMD_OVW_LIMIT, 16'h0005);
			begin
				step(1);
				nvm_restore = 1'b1;
				step(1);
				nvm_restore = 1'b0;
			end
		join
		rd(`IVP_CMD_OVW_LIMIT, 1'b1, 16'h0013);
		wr(`IVP_CMD_OVW_LIMIT, 16'h000F);
		// Undervoltage warning stays masked until armed
		chk_bit(uvw, 1'b0);
		vin_sense = 16'h0500;
		step(2);
		vin_sense = 16'h0400;
		step(2);
		chk_bit(uvw, 1'b0);
		vin_sense = 16'h0A00;
		step(2);
		vin_sense = 16'h0400;
		step(2);
		chk_bit(uvw, 1'b1);
		chk_bit(summ & inb & ~alert_b, 1'b1);
		vin_sense = 16'h0A00;
		step(3);
		chk_bit(uvw, 1'b1);
		clr;
		chk_bit(uvw | ~alert_b, 1'b0);
		wr(`IVP_CMD_OV_ACTION, 16'h0000);
		vin_sense = 16'h0F80;
		step(2);
		chk_bit(ovw & ovf & summ & inb, 1'b1);
		chk_bit(conv, 1'b1);
		vin_sense = 16'h0A00;
		clr;
		wr(`IVP_CMD_OV_ACTION, 16'h0080);
		vin_sense = 16'h0D00;
		step(2);
		chk_bit(shut & ovf & ~ovw, 1'b1);
		vin_sense = 16'h0A00;
		step(20);
		chk_bit(conv, 1'b0);
		unit_on = 1'b0;
		step(2);
		chk_bit(shut, 1'b0);
		unit_on = 1'b1;
		step(2);
		chk_bit(conv, 1'b1);
		wr(`IVP_CMD_OV_ACTION, 16'h00B8);
		vin_sense = 16'h0D00;
		step(1);
		vin_sense = 16'h0A00;
		step(12);
		chk_bit(conv, 1'b0);
		n = 0;
		while (conv !== 1'b1 && n < 10) begin
			step(1);
			n++;
		end
		chk_bit(conv, 1'b1);
		chk_bit(n == 4, 1'b1);
		// Selector zero gives the bare base wait of 8 cycles
		protection_configuration = 2'h0;
		vin_sense = 16'h0D00;
		step(1);
		vin_sense = 16'h0A00;
		chk_bit(shut & ~conv, 1'b1);
		n = 0;
		while (conv !== 1'b1 && n < 20) begin
			step(1);
			n++;
		end
		chk_bit(n == 8, 1'b1);
		summarize;
	end
endmodule
`default_nettype wire

// >>> hdl/ivp_defines.vh
// Command codes, field layout, reset values and timing for input-voltage protection
`ifndef IVP_DEFINES_VH
`define IVP_DEFINES_VH

// Command codes
`define IVP_CMD_OVF_LIMIT      8'h55
`define IVP_CMD_OV_ACTION      8'h56
`define IVP_CMD_OVW_LIMIT      8'h57
`define IVP_CMD_UVW_LIMIT      8'h58

// Field positions
`define IVP_EXP_HI             15
`define IVP_EXP_LO             11
`define IVP_MAN_HI             10
`define IVP_ACT_HI             7
`define IVP_ACT_LO             3

// Reset values
`define IVP_OVF_EXP_RST        5'h00
`define IVP_OVW_EXP_RST        5'h00
`define IVP_UVW_EXP_RST        5'h1E
`define IVP_MAN_RST            11'h000
`define IVP_ACT_RST            5'h00

// Action codes
`define IVP_ACT_IGNORE         5'h00
`define IVP_ACT_LATCH          5'h10
`define IVP_ACT_HICCUP         5'h17

// Limits in 1/256 V steps
`define IVP_OV_MIN_Q8          24'h000000
`define IVP_OV_MAX_Q8          24'h001300
`define IVP_UV_MIN_Q8          24'h000400
`define IVP_UV_MAX_Q8          24'h000B40

// Restore quantisation
`define IVP_OV_REST_MAX        17'h00013
`define IVP_UV_REST_MIN        17'h00010
`define IVP_UV_REST_MAX        17'h0002D
`define IVP_OV_ROUND_ADD       17'h00080
`define IVP_UV_ROUND_ADD       17'h00020

// Hiccup base period
`define IVP_CLK_MHZ            100
`define IVP_HICCUP_BASE_US     20000
`define IVP_HICCUP_BASE_CYC    (`IVP_HICCUP_BASE_US * `IVP_CLK_MHZ)

`endif

// >>> hdl/ivp_fault_ctl.v
// Input overvoltage fault response sequencer: ignore, latch-off or hiccup
`default_nettype none
`include "ivp_defines.vh"

module ivp_fault_ctl #(
	parameter HICCUP_BASE_CYC = `IVP_HICCUP_BASE_CYC
) (
	// Clock and reset
	input  wire       clock,
	input  wire       rst_b,
	// Control
	input  wire       fault,
	input  wire [4:0] action,
	input  wire [1:0] hiccup_sel,
	input  wire       unit_on,
	// Status
	output wire       conv_enable,
	output wire       shutdown_active
);

	localparam [2:0] ST_RUN    = 3'b001;
	localparam [2:0] ST_LATCH  = 3'b010;
	localparam [2:0] ST_HICCUP = 3'b100;

	reg [2:0]  state_q;
	reg [2:0]  state_d;
	reg [34:0] count_q;
	reg [34:0] count_d;
	wire [34:0] period;

	// Each step of the selector doubles the wait
	assign period = {3'b000, HICCUP_BASE_CYC[31:0]} << hiccup_sel;

	always @* begin
		state_d = state_q;
		count_d = count_q;
		case (state_q)
			ST_RUN: begin
				if (fault && unit_on) begin
					if (action == `IVP_ACT_LATCH) begin
						state_d = ST_LATCH;
					end else if (action == `IVP_ACT_HICCUP) begin
						state_d = ST_HICCUP;
						count_d = period;
					end
				end
			end
			ST_LATCH: begin
				// Cleared only by commanding the unit off
				if (!unit_on) begin
					state_d = ST_RUN;
				end
			end
			ST_HICCUP: begin
				if (!unit_on || count_q <= 35'd1) begin
					state_d = ST_RUN;
					count_d = 35'd0;
				end else begin
					count_d = count_q - 35'd1;
				end
			end
			default: begin
				state_d = ST_RUN;
				count_d = 35'd0;
			end
		endcase
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_RUN;
			count_q <= 35'd0;
		end else begin
			state_q <= state_d;
			count_q <= count_d;
		end
	end

	// Code 00000b never leaves RUN, so conversion continues
	assign conv_enable     = unit_on && state_q == ST_RUN;
	assign shutdown_active = state_q != ST_RUN;

endmodule
`default_nettype wire

// >>> hdl/ivp_lin_decode.v
// Linear-format (5-bit exponent, 11-bit mantissa) to signed 1/256 V decoder
`default_nettype none

module ivp_lin_decode (
	// Linear-format word
	input  wire        [15:0] lin,
	// Value in 1/256 V steps, saturated
	output reg  signed [23:0] q8
);

	reg signed [6:0]  sh;
	reg signed [6:0]  nsh;
	reg signed [39:0] man;
	reg signed [39:0] wide;

	always @* begin
		sh   = $signed({{2{lin[15]}}, lin[15:11]}) + 7'sd8;
		nsh  = -sh;
		man  = $signed({{29{lin[10]}}, lin[10:0]});
		if (sh >= 7'sd0) begin
			wide = man <<< sh[5:0];
		end else begin
			wide = man >>> nsh[5:0];
		end
		// Saturate so a huge exponent cannot wrap into a small limit
		if (wide > 40'sh00007FFFFF) begin
			q8 = 24'sh7FFFFF;
		end else if (wide < -40'sh0000800000) begin
			q8 = -24'sh800000;
		end else begin
			q8 = wide[23:0];
		end
	end

endmodule
`default_nettype wire

// >>> hdl/ivp_regs.v
// Input-voltage protection command registers, comparators and status flags
// Summary of operation
// - Programmable overvoltage fault limit; crossing raises a fault handled by the action byte.
// - Restore sets fault limit to nearest whole volt 0..19, encoded 0000h..0013h.
// - One-byte fault action command at 56h, byte write and byte read.
// - Overvoltage fault sets summary, input and fault flags, then alerts host.
// - Action code in bits 7:3 restored from memory; bits 2:0 read zero.
// - Code 00000b ignores fault; 10000b shuts down and stays off.
// - Code 10111b shuts down, waits one hiccup period, retries until on or off.
// - Unlisted codes or out-of-range limits are invalid data: flag and alert.
// - 16-bit linear overvoltage warning limit at 57h, word access.
// - Input above warning limit sets summary, input and warning flags, alerts.
// - Warning limit exponent bits 15:11 reset 00000b; mantissa restored from memory.
// - Restore sets warning limit to nearest whole volt 0..19, 0000h..0013h.
// - Run-time writes with fine resolution accepted inside the supported range.
// - Input below undervoltage warning limit sets summary, input and warning flags.
// - Undervoltage warning masked until input first exceeds turn-on and limit.
// - Undervoltage warning limit at 58h; exponent resets 11110b, mantissa restored.
// - Restore sets undervoltage limit to nearest 0.25 V, 4.00..11.25 V, F010h..F02Dh.
`default_nettype none
`include "ivp_defines.vh"

module ivp_regs #(
	parameter HICCUP_BASE_CYC = `IVP_HICCUP_BASE_CYC
) (
	// Clock and reset
	input  wire        clock,
	input  wire        rst_b,
	// Command port from the bus transport
	input  wire        cmd_req,
	input  wire        cmd_wr,
	input  wire [7:0]  cmd_code,
	input  wire [15:0] cmd_wdata,
	output reg         rsp_valid,
	output reg         rsp_hit,
	output reg  [15:0] rsp_rdata,
	// Stored values, 1/256 V steps, and restore request
	input  wire        nvm_restore,
	input  wire [15:0] nvm_ovf_limit,
	input  wire [15:0] nvm_ovw_limit,
	input  wire [15:0] nvm_uvw_limit,
	input  wire [4:0]  nvm_ov_action,
	// Telemetry and control, same clock
	input  wire [15:0] vin_sense,
	input  wire [15:0] vin_on_level,
	input  wire [1:0]  protection_configuration,
	input  wire        unit_on,
	input  wire        status_clear,
	// Status
	output reg         input_overvoltage_fault_flag,
	output reg         input_overvoltage_warning_flag,
	output reg         input_undervoltage_warning_flag,
	output reg         invalid_data_flag,
	output wire        other_fault_summary_bit,
	output wire        status_word_input_bit,
	output wire        cml_summary_bit,
	output wire        alert_b,
	output wire        conv_enable,
	output wire        shutdown_active
);

	reg        restore_pend_q;
	reg [15:0] ovf_limit_q;
	reg [15:0] ovw_limit_q;
	reg [15:0] uvw_limit_q;
	reg [4:0]  overvoltage_action_code;
	reg        uv_armed_q;
	reg        inv_set;

	wire signed [23:0] wr_q8;
	wire signed [23:0] ovf_q8;
	wire signed [23:0] ovw_q8;
	wire signed [23:0] uvw_q8;
	wire signed [24:0] vin_s;
	wire signed [24:0] von_s;
	wire               do_wr;
	wire               ov_range_ok;
	wire               uv_range_ok;
	wire               act_ok;
	wire               ovf_cond;
	wire               ovw_cond;
	wire               uvw_cond;
	wire               restore;

	// Nearest whole volt, clamped to 19
	function [15:0] rest_ov;
		input [15:0] v;
		reg   [16:0] n;
		begin
			n = ({1'b0, v} + `IVP_OV_ROUND_ADD) >> 8;
			if (n > `IVP_OV_REST_MAX) begin
				n = `IVP_OV_REST_MAX;
			end
			rest_ov = {`IVP_OVW_EXP_RST, n[10:0]};
		end
	endfunction

	// Nearest quarter volt, clamped to 4.00..11.25
	function [15:0] rest_uv;
		input [15:0] v;
		reg   [16:0] n;
		begin
			n = ({1'b0, v} + `IVP_UV_ROUND_ADD) >> 6;
			if (n > `IVP_UV_REST_MAX) begin
				n = `IVP_UV_REST_MAX;
			end else if (n < `IVP_UV_REST_MIN) begin
				n = `IVP_UV_REST_MIN;
			end
			rest_uv = {`IVP_UVW_EXP_RST, n[10:0]};
		end
	endfunction

	// Listed action codes only
	function valid_action;
		input [4:0] a;
		begin
			valid_action = a == `IVP_ACT_IGNORE || a == `IVP_ACT_LATCH ||
				a == `IVP_ACT_HICCUP;
		end
	endfunction

	// Limits decoded into sense units
	ivp_lin_decode u_dec_wr (
		.lin (cmd_wdata),
		.q8  (wr_q8)
	);

	ivp_lin_decode u_dec_ovf (
		.lin (ovf_limit_q),
		.q8  (ovf_q8)
	);

	ivp_lin_decode u_dec_ovw (
		.lin (ovw_limit_q),
		.q8  (ovw_q8)
	);

	ivp_lin_decode u_dec_uvw (
		.lin (uvw_limit_q),
		.q8  (uvw_q8)
	);

	assign restore = restore_pend_q || nvm_restore;
	assign do_wr   = cmd_req && cmd_wr;

	assign ov_range_ok = wr_q8 >= $signed(`IVP_OV_MIN_Q8) &&
		wr_q8 <= $signed(`IVP_OV_MAX_Q8);
	assign uv_range_ok = wr_q8 >= $signed(`IVP_UV_MIN_Q8) &&
		wr_q8 <= $signed(`IVP_UV_MAX_Q8);
	assign act_ok      = valid_action(cmd_wdata[`IVP_ACT_HI:`IVP_ACT_LO]);

	// Sense and turn-on level widened so both compare as signed
	assign vin_s = $signed({9'h000, vin_sense});
	assign von_s = $signed({9'h000, vin_on_level});

	assign ovf_cond = vin_s > $signed({ovf_q8[23], ovf_q8});
	assign ovw_cond = vin_s > $signed({ovw_q8[23], ovw_q8});
	assign uvw_cond = uv_armed_q && vin_s < $signed({uvw_q8[23], uvw_q8});

	// Limit and action storage
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			// One automatic restore follows every reset
			restore_pend_q          <= 1'b1;
			ovf_limit_q             <= {`IVP_OVF_EXP_RST, `IVP_MAN_RST};
			ovw_limit_q             <= {`IVP_OVW_EXP_RST, `IVP_MAN_RST};
			uvw_limit_q             <= {`IVP_UVW_EXP_RST, `IVP_MAN_RST};
			overvoltage_action_code <= `IVP_ACT_RST;
		end else begin
			restore_pend_q <= 1'b0;
			// Restore overrides a write in the same cycle
			if (restore) begin
				ovf_limit_q             <= rest_ov(nvm_ovf_limit);
				ovw_limit_q             <= rest_ov(nvm_ovw_limit);
				uvw_limit_q             <= rest_uv(nvm_uvw_limit);
				overvoltage_action_code <= nvm_ov_action;
			end else if (do_wr) begin
				case (cmd_code)
					`IVP_CMD_OVF_LIMIT: begin
						if (ov_range_ok) begin
							ovf_limit_q <= cmd_wdata;
						end
					end
					`IVP_CMD_OV_ACTION: begin
						// Takes effect at once; no guard against mid-shutdown writes
						if (act_ok) begin
							overvoltage_action_code <=
								cmd_wdata[`IVP_ACT_HI:`IVP_ACT_LO];
						end
					end
					`IVP_CMD_OVW_LIMIT: begin
						if (ov_range_ok) begin
							ovw_limit_q <= cmd_wdata;
						end
					end
					`IVP_CMD_UVW_LIMIT: begin
						if (uv_range_ok) begin
							uvw_limit_q <= cmd_wdata;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Invalid write detection
	always @* begin
		inv_set = 1'b0;
		if (do_wr) begin
			case (cmd_code)
				`IVP_CMD_OVF_LIMIT: inv_set = !ov_range_ok;
				`IVP_CMD_OV_ACTION: inv_set = !act_ok;
				`IVP_CMD_OVW_LIMIT: inv_set = !ov_range_ok;
				`IVP_CMD_UVW_LIMIT: inv_set = !uv_range_ok;
				default:            inv_set = 1'b0;
			endcase
		end
	end

	// Read answers, one cycle after the request
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rsp_valid <= 1'b0;
			rsp_hit   <= 1'b0;
			rsp_rdata <= 16'h0000;
		end else begin
			// Writes and unknown codes answer zero so stale data never leaks
			rsp_valid <= cmd_req;
			rsp_hit   <= 1'b0;
			rsp_rdata <= 16'h0000;
			if (cmd_req) begin
				rsp_hit <= cmd_code == `IVP_CMD_OVF_LIMIT || cmd_code == `IVP_CMD_OV_ACTION ||
					cmd_code == `IVP_CMD_OVW_LIMIT || cmd_code == `IVP_CMD_UVW_LIMIT;
				if (!cmd_wr) begin
					case (cmd_code)
						`IVP_CMD_OVF_LIMIT: rsp_rdata <= ovf_limit_q;
						`IVP_CMD_OV_ACTION: rsp_rdata <= {8'h00, overvoltage_action_code, 3'b000};
						`IVP_CMD_OVW_LIMIT: rsp_rdata <= ovw_limit_q;
						`IVP_CMD_UVW_LIMIT: rsp_rdata <= uvw_limit_q;
						default:            rsp_rdata <= 16'h0000;
					endcase
				end
			end
		end
	end

	// Undervoltage warning arming
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			uv_armed_q <= 1'b0;
		end else if (vin_s > von_s && vin_s > $signed({uvw_q8[23], uvw_q8})) begin
			// Stays armed until reset, so a later dip below turn-on still warns
			uv_armed_q <= 1'b1;
		end
	end

	// Sticky flags; a set in the clearing cycle wins
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			input_overvoltage_fault_flag    <= 1'b0;
			input_overvoltage_warning_flag  <= 1'b0;
			input_undervoltage_warning_flag <= 1'b0;
			invalid_data_flag               <= 1'b0;
		end else begin
			input_overvoltage_fault_flag <=
				ovf_cond || (input_overvoltage_fault_flag && !status_clear);
			input_overvoltage_warning_flag <=
				ovw_cond || (input_overvoltage_warning_flag && !status_clear);
			input_undervoltage_warning_flag <=
				uvw_cond || (input_undervoltage_warning_flag && !status_clear);
			invalid_data_flag <=
				inv_set || (invalid_data_flag && !status_clear);
		end
	end

	assign status_word_input_bit   = input_overvoltage_fault_flag ||
		input_overvoltage_warning_flag || input_undervoltage_warning_flag;
	assign other_fault_summary_bit = status_word_input_bit;
	assign cml_summary_bit         = invalid_data_flag;
	// Alert held while anything is pending
	assign alert_b = !(status_word_input_bit || invalid_data_flag);

	ivp_fault_ctl #(
		.HICCUP_BASE_CYC (HICCUP_BASE_CYC)
	) u_fault_ctl (
		.clock           (clock),
		.rst_b           (rst_b),
		.fault           (ovf_cond),
		.action          (overvoltage_action_code),
		.hiccup_sel      (protection_configuration),
		.unit_on         (unit_on),
		.conv_enable     (conv_enable),
		.shutdown_active (shutdown_active)
	);

endmodule
`default_nettype wire
